// ===== src/wbr_pkg.sv
package wbr_pkg;

  // Half clock unit: one HALF_CLOCK_UNIT is half a CPU clock period at 125 MHz (4 ns)
  localparam int unsigned CLK_PERIOD_PS = 8000;
  localparam int unsigned TCL_PS = CLK_PERIOD_PS / 2;
  // Internal reset sequence, printed in HALF_CLOCK_UNIT units
  localparam int unsigned SEQ_TCL = 1024;
  localparam int unsigned SAMPLE_TCL = 8;
  localparam int unsigned SHORT_MIN_TCL = 4;
  localparam int unsigned SEQ_CYC = (SEQ_TCL * TCL_PS) / CLK_PERIOD_PS;
  localparam int unsigned SAMPLE_CYC =
    (SAMPLE_TCL * TCL_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned SHORT_MIN_CYC =
    (SHORT_MIN_TCL * TCL_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  // Extra cycles the flash init adds when booting internally
  localparam int unsigned FLASH_INIT_CYC = 16;

  // AXI4-Lite register byte addresses
  localparam logic [3:0] ADDR_SYSCFG = 4'h0;
  localparam logic [3:0] ADDR_SOURCE = 4'h4;
  localparam logic [3:0] ADDR_CFGPORT = 4'h8;
  localparam logic [3:0] ADDR_STATUS = 4'hc;

  // System configuration fields
  localparam int unsigned BIT_BIDIR_EN = 0;
  localparam int unsigned BIT_PD_PULLUP = 1;
  localparam int unsigned BIT_WDT_EN = 2;
  localparam logic [2:0] SYSCFG_RST = 3'h4;

  // Reset source flags
  localparam int unsigned SRC_LHW = 0;
  localparam int unsigned SRC_SHW = 1;
  localparam int unsigned SRC_SW = 2;
  localparam int unsigned SRC_WDT = 3;
  localparam int unsigned SRC_ASYNC = 4;
  localparam logic [4:0] SOURCE_RST = 5'h00;

  localparam logic [15:0] CFGPORT_RST = 16'h0000;
  localparam logic [15:0] CFG_FORCE_ONES = 16'h00fc;
  localparam logic [15:0] CFG_LATCH_MASK = 16'h1f00;
  localparam logic [15:0] WDT_RELOAD = 16'hffff;

  typedef enum logic [2:0] {
    ST_RUN = 3'b000,
    ST_BUS_WAIT = 3'b001,
    ST_SEQ = 3'b010,
    ST_SAMPLE = 3'b011,
    ST_LONG = 3'b100,
    ST_INIT = 3'b101,
    ST_ASYNC = 3'b110
  } wbr_state_e;

  typedef enum logic [1:0] {
    KIND_HW = 2'b00,
    KIND_SW = 2'b01,
    KIND_WDT = 2'b10
  } wbr_kind_e;

  typedef struct packed {
    logic ext_active;
    logic ext_uses_ready;
    logic ready_n;
    logic waits_done;
  } wbr_bus_s;

endpackage : wbr_pkg

// ===== src/wbr_seq.sv
// Our own choices: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module wbr_seq (
  input wire logic clk_sys, // CPU clock
  input wire logic rst_n, // Power-on reset, async
  input wire logic filtered_reset_in, // Filtered reset input, low active
  input wire logic reset_in_pin, // Reset pin level as seen
  input wire logic powerdown_sense_pin, // Power-down sense level
  input wire logic external_boot_select, // High: internal flash boot
  input wire logic software_reset_instr, // Protected reset executed
  input wire logic end_of_init_instr, // End-of-init completed
  input wire logic wdt_service, // Watchdog serviced
  input wire wbr_pkg::wbr_bus_s bus, // External bus status
  input wire logic [15:0] config_port_pins, // Config port pin levels
  output logic bus_abort, // Abort running bus cycle
  output logic reset_in_oe, // Open-drain pull on reset pin
  output logic reset_in_o, // Value driven, always low
  output logic reset_out_pin, // Reset output, low active
  output logic cpu_reset, // Core held in reset
  output logic sense_pulldown, // Weak pull-down on sense pin
  output logic sense_pullup, // Pull-up on sense pin
  output logic [15:0] config_port, // Latched configuration
  input wire logic [3:0] s_axi_awaddr, // AXI4-Lite
  input wire logic s_axi_awvalid, // AXI4-Lite
  output logic s_axi_awready, // AXI4-Lite
  input wire logic [31:0] s_axi_wdata, // AXI4-Lite
  input wire logic [3:0] s_axi_wstrb, // AXI4-Lite
  input wire logic s_axi_wvalid, // AXI4-Lite
  output logic s_axi_wready, // AXI4-Lite
  output logic [1:0] s_axi_bresp, // AXI4-Lite
  output logic s_axi_bvalid, // AXI4-Lite
  input wire logic s_axi_bready, // AXI4-Lite
  input wire logic [3:0] s_axi_araddr, // AXI4-Lite
  input wire logic s_axi_arvalid, // AXI4-Lite
  output logic s_axi_arready, // AXI4-Lite
  output logic [31:0] s_axi_rdata, // AXI4-Lite
  output logic [1:0] s_axi_rresp, // AXI4-Lite
  output logic s_axi_rvalid, // AXI4-Lite
  input wire logic s_axi_rready // AXI4-Lite
);

  typedef struct packed {
    wbr_pkg::wbr_state_e st;
    wbr_pkg::wbr_kind_e kind;
    logic [10:0] cnt;
    logic [2:0] low_cnt;
    logic bidir_drive;
    logic in_init;
    logic [2:0] syscfg;
    logic [4:0] source;
    logic [15:0] cfg;
    logic [15:0] wdt;
    logic sy1;
    logic sy2;
    logic aw_got;
    logic w_got;
    logic [3:0] aw_a;
    logic [31:0] w_d;
    logic [3:0] w_s;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic abort;
    logic oe;
    logic rout;
    logic crst;
    logic pd;
    logic pu;
  } wbr_regs_s;

  wbr_regs_s r;
  wbr_regs_s next_r;
  logic rst_low;
  logic wr_fire;
  logic [10:0] seq_len;
  logic [31:0] rd_val;

  assign rst_low = ~r.sy2;

  // Flash init stretches the sequence past the input filter
  assign seq_len = external_boot_select ?
    11'(wbr_pkg::SEQ_CYC + wbr_pkg::FLASH_INIT_CYC) :
    11'(wbr_pkg::SEQ_CYC);

  assign wr_fire = r.aw_got & r.w_got & ~r.bvalid;

  always_comb begin
    rd_val = 32'h0000_0000;
    case (s_axi_araddr)
      wbr_pkg::ADDR_SYSCFG: rd_val = {29'h0, r.syscfg};
      wbr_pkg::ADDR_SOURCE: rd_val = {27'h0, r.source};
      wbr_pkg::ADDR_CFGPORT: rd_val = {16'h0, r.cfg};
      wbr_pkg::ADDR_STATUS: rd_val = {27'h0, r.in_init, r.kind,
        r.st != wbr_pkg::ST_RUN, rst_low};
      default: rd_val = 32'h0000_0000;
    endcase
  end

  always_comb begin
    next_r = r;
    next_r.sy1 = filtered_reset_in;
    next_r.sy2 = r.sy1;
    next_r.abort = 1'b0;
    if (end_of_init_instr) begin
      next_r.in_init = 1'b0;
    end
    case (r.st)
      wbr_pkg::ST_RUN: begin
        next_r.wdt = r.syscfg[wbr_pkg::BIT_WDT_EN] ?
          (wdt_service ? wbr_pkg::WDT_RELOAD : r.wdt - 16'h0001) :
          wbr_pkg::WDT_RELOAD;
        next_r.cnt = 11'h000;
        if (rst_low && !powerdown_sense_pin) begin
          next_r.st = wbr_pkg::ST_ASYNC;
          next_r.source = 5'h1f & (5'h1 << wbr_pkg::SRC_ASYNC);
        end else if (r.low_cnt >= 3'(wbr_pkg::SHORT_MIN_CYC)) begin
          next_r.st = wbr_pkg::ST_SEQ;
          next_r.kind = wbr_pkg::KIND_HW;
          next_r.source = 5'h1 << wbr_pkg::SRC_SHW;
        end else if (software_reset_instr) begin
          next_r.st = wbr_pkg::ST_SEQ;
          next_r.kind = wbr_pkg::KIND_SW;
          next_r.source = 5'h1 << wbr_pkg::SRC_SW;
        end else if (r.syscfg[wbr_pkg::BIT_WDT_EN] && r.wdt == 16'h0000) begin
          next_r.kind = wbr_pkg::KIND_WDT;
          next_r.source = 5'h1 << wbr_pkg::SRC_WDT;
          next_r.st = bus.ext_active ? wbr_pkg::ST_BUS_WAIT :
                                      wbr_pkg::ST_SEQ;
        end
        // Hardware short reset counter: cycles of low filtered input while running
        next_r.low_cnt = rst_low ? r.low_cnt + 3'h1 : 3'h0;
        if (next_r.st != wbr_pkg::ST_RUN) begin
          next_r.syscfg[wbr_pkg::BIT_BIDIR_EN] = 1'b0;
          next_r.in_init = 1'b1;
          next_r.rout = 1'b0;
          next_r.crst = 1'b1;
          next_r.low_cnt = 3'h0;
          // No pull at all when the sense pin is already low
          next_r.bidir_drive = r.syscfg[wbr_pkg::BIT_BIDIR_EN] &
            powerdown_sense_pin;
        end
      end
      wbr_pkg::ST_BUS_WAIT: begin
        if (!bus.ext_active) begin
          next_r.st = wbr_pkg::ST_SEQ;
        end else if (bus.waits_done) begin
          if (bus.ext_uses_ready && bus.ready_n) begin
            next_r.abort = 1'b1;
            next_r.st = wbr_pkg::ST_SEQ;
          end
        end
      end
      wbr_pkg::ST_SEQ: begin
        next_r.cnt = r.cnt + 11'h001;
        if (r.kind == wbr_pkg::KIND_HW && rst_low &&
            !powerdown_sense_pin) begin
          next_r.st = wbr_pkg::ST_ASYNC;
          next_r.source = 5'h1 << wbr_pkg::SRC_ASYNC;
        end else if (r.cnt + 11'h001 >= seq_len) begin
          next_r.cnt = 11'h000;
          next_r.bidir_drive = 1'b0;
          if (r.kind == wbr_pkg::KIND_HW && r.bidir_drive) begin
            next_r.st = wbr_pkg::ST_SAMPLE;
          end else if (r.bidir_drive) begin
            next_r.st = wbr_pkg::ST_SAMPLE;
          end else begin
            next_r.st = rst_low && r.kind == wbr_pkg::KIND_HW ?
              wbr_pkg::ST_LONG : wbr_pkg::ST_INIT;
          end
        end
        // Sense low stops the pull but not the count
        if (!powerdown_sense_pin) begin
          next_r.bidir_drive = 1'b0;
        end
      end
      wbr_pkg::ST_SAMPLE: begin
        next_r.cnt = r.cnt + 11'h001;
        if (r.cnt + 11'h001 >= 11'(wbr_pkg::SAMPLE_CYC)) begin
          next_r.cnt = 11'h000;
          if (!rst_low) begin
            next_r.st = wbr_pkg::ST_INIT;
          end else if (r.kind == wbr_pkg::KIND_HW) begin
            next_r.st = wbr_pkg::ST_LONG;
            next_r.source = 5'h1 << wbr_pkg::SRC_LHW;
          end else begin
            next_r.kind = wbr_pkg::KIND_HW;
            next_r.source = 5'h1 << wbr_pkg::SRC_SHW;
            next_r.st = wbr_pkg::ST_SEQ;
          end
        end
      end
      wbr_pkg::ST_LONG: begin
        if (rst_low && !powerdown_sense_pin) begin
          next_r.st = wbr_pkg::ST_ASYNC;
          next_r.source = 5'h1 << wbr_pkg::SRC_ASYNC;
        end else if (!rst_low) begin
          next_r.st = wbr_pkg::ST_INIT;
          next_r.source = 5'h1 << wbr_pkg::SRC_LHW;
        end
      end
      wbr_pkg::ST_ASYNC: begin
        if (!rst_low && powerdown_sense_pin) begin
          next_r.st = wbr_pkg::ST_INIT;
        end
      end
      wbr_pkg::ST_INIT: begin
        next_r.st = wbr_pkg::ST_RUN;
        next_r.crst = 1'b0;
        next_r.wdt = wbr_pkg::WDT_RELOAD;
        if (r.kind == wbr_pkg::KIND_HW) begin
          next_r.cfg = config_port_pins;
        end else begin
          next_r.cfg = (config_port_pins & wbr_pkg::CFG_LATCH_MASK) |
            (r.cfg & ~wbr_pkg::CFG_LATCH_MASK) |
            wbr_pkg::CFG_FORCE_ONES;
        end
        next_r.pu = r.syscfg[wbr_pkg::BIT_PD_PULLUP];
      end
      default: next_r.st = wbr_pkg::ST_RUN;
    endcase
    if (r.st == wbr_pkg::ST_RUN && !r.in_init && r.crst == 1'b0 &&
        next_r.st == wbr_pkg::ST_RUN) begin
      next_r.rout = 1'b1;
    end
    next_r.oe = next_r.bidir_drive;
    next_r.pd = ~reset_in_pin;

    // AXI4-Lite slave
    if (s_axi_awvalid && r.awready) begin
      next_r.aw_got = 1'b1;
      next_r.aw_a = s_axi_awaddr;
    end
    if (s_axi_wvalid && r.wready) begin
      next_r.w_got = 1'b1;
      next_r.w_d = s_axi_wdata;
      next_r.w_s = s_axi_wstrb;
    end
    next_r.awready = ~next_r.aw_got & ~r.bvalid;
    next_r.wready = ~next_r.w_got & ~r.bvalid;
    if (wr_fire) begin
      next_r.bvalid = 1'b1;
      next_r.bresp = 2'b00;
      next_r.aw_got = 1'b0;
      next_r.w_got = 1'b0;
      next_r.awready = 1'b0;
      next_r.wready = 1'b0;
      if (r.aw_a == wbr_pkg::ADDR_SYSCFG && r.w_s[0]) begin
        next_r.syscfg[wbr_pkg::BIT_PD_PULLUP] =
          r.w_d[wbr_pkg::BIT_PD_PULLUP];
        next_r.syscfg[wbr_pkg::BIT_WDT_EN] = r.w_d[wbr_pkg::BIT_WDT_EN];
        if (r.in_init && r.st == wbr_pkg::ST_RUN) begin
          next_r.syscfg[wbr_pkg::BIT_BIDIR_EN] =
            r.w_d[wbr_pkg::BIT_BIDIR_EN];
        end
      end else if (r.aw_a != wbr_pkg::ADDR_SOURCE &&
                   r.aw_a != wbr_pkg::ADDR_CFGPORT &&
                   r.aw_a != wbr_pkg::ADDR_STATUS) begin
        next_r.bresp = 2'b10;
      end
    end else if (r.bvalid && s_axi_bready) begin
      next_r.bvalid = 1'b0;
      next_r.awready = ~r.aw_got;
      next_r.wready = ~r.w_got;
    end
    if (s_axi_arvalid && r.arready) begin
      next_r.arready = 1'b0;
      next_r.rvalid = 1'b1;
      next_r.rdata = rd_val;
      next_r.rresp = (s_axi_araddr > wbr_pkg::ADDR_STATUS ||
                      s_axi_araddr[1:0] != 2'b00) ? 2'b10 : 2'b00;
    end else if (r.rvalid && s_axi_rready) begin
      next_r.rvalid = 1'b0;
      next_r.arready = 1'b1;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      r <= '0;
      r.st <= wbr_pkg::ST_INIT;
      r.kind <= wbr_pkg::KIND_HW;
      r.syscfg <= wbr_pkg::SYSCFG_RST;
      r.source <= wbr_pkg::SOURCE_RST;
      r.cfg <= wbr_pkg::CFGPORT_RST;
      r.wdt <= wbr_pkg::WDT_RELOAD;
      r.in_init <= 1'b1;
      r.crst <= 1'b1;
      r.sy1 <= 1'b1;
      r.sy2 <= 1'b1;
      r.awready <= 1'b1;
      r.wready <= 1'b1;
      r.arready <= 1'b1;
    end else begin
      r <= next_r;
    end
  end

  assign bus_abort = r.abort;
  assign reset_in_oe = r.oe;
  assign reset_in_o = 1'b0;
  assign reset_out_pin = r.rout;
  assign cpu_reset = r.crst;
  assign sense_pulldown = r.pd;
  assign sense_pullup = r.pu;
  assign config_port = r.cfg;
  assign s_axi_awready = r.awready;
  assign s_axi_wready = r.wready;
  assign s_axi_bvalid = r.bvalid;
  assign s_axi_bresp = r.bresp;
  assign s_axi_arready = r.arready;
  assign s_axi_rvalid = r.rvalid;
  assign s_axi_rdata = r.rdata;
  assign s_axi_rresp = r.rresp;

  property p_bidir_clear;
    @(posedge clk_sys) disable iff (!rst_n)
      (r.st == wbr_pkg::ST_RUN && next_r.st == wbr_pkg::ST_SEQ) |=>
      !r.syscfg[wbr_pkg::BIT_BIDIR_EN];
  endproperty
  a_bidir_clear: assert property (p_bidir_clear)
    else $error("bidir enable not cleared at reset start");

  property p_rout_low;
    @(posedge clk_sys) disable iff (!rst_n)
      (r.st == wbr_pkg::ST_SEQ) |-> !reset_out_pin;
  endproperty
  a_rout_low: assert property (p_rout_low)
    else $error("reset output high during sequence");

  property p_sense_release;
    @(posedge clk_sys) disable iff (!rst_n)
      (r.st == wbr_pkg::ST_SEQ && !powerdown_sense_pin) |=> !reset_in_oe;
  endproperty
  a_sense_release: assert property (p_sense_release)
    else $error("reset pin still pulled with sense low");

  property p_pulldown;
    @(posedge clk_sys) disable iff (!rst_n)
      !reset_in_pin |=> sense_pulldown;
  endproperty
  a_pulldown: assert property (p_pulldown)
    else $error("sense pull-down missing");

  property p_wdt_start;
    @(posedge clk_sys) disable iff (!rst_n)
      (r.st == wbr_pkg::ST_RUN && r.syscfg[wbr_pkg::BIT_WDT_EN] &&
       r.wdt == 16'h0000 && !rst_low && !software_reset_instr &&
       r.low_cnt < 3'(wbr_pkg::SHORT_MIN_CYC)) |=> cpu_reset;
  endproperty
  a_wdt_start: assert property (p_wdt_start)
    else $error("watchdog overflow did not reset");

  property p_abort;
    @(posedge clk_sys) disable iff (!rst_n)
      bus_abort |-> $past(r.st) == wbr_pkg::ST_BUS_WAIT;
  endproperty
  a_abort: assert property (p_abort)
    else $error("abort outside bus wait");

  property p_force_ones;
    @(posedge clk_sys) disable iff (!rst_n)
      (r.st == wbr_pkg::ST_INIT && r.kind != wbr_pkg::KIND_HW) |=>
      (config_port & wbr_pkg::CFG_FORCE_ONES) == wbr_pkg::CFG_FORCE_ONES;
  endproperty
  a_force_ones: assert property (p_force_ones)
    else $error("config bits 7:2 not forced to one");

  property p_async;
    @(posedge clk_sys) disable iff (!rst_n)
      (r.st == wbr_pkg::ST_LONG && rst_low && !powerdown_sense_pin) |=>
      r.st == wbr_pkg::ST_ASYNC;
  endproperty
  a_async: assert property (p_async)
    else $error("no async reset on sense low");

  c_wdt: cover property (@(posedge clk_sys) disable iff (!rst_n)
    r.st == wbr_pkg::ST_SEQ && r.kind == wbr_pkg::KIND_WDT);
  c_degen: cover property (@(posedge clk_sys) disable iff (!rst_n)
    r.st == wbr_pkg::ST_SAMPLE ##1 r.st == wbr_pkg::ST_SEQ);
  c_long: cover property (@(posedge clk_sys) disable iff (!rst_n)
    r.st == wbr_pkg::ST_LONG);

endmodule : wbr_seq
`default_nettype wire

// ===== bench/wbr_ext_model.sv
`timescale 1ns/1ps
`default_nettype none
module wbr_ext_model (
  input wire logic clk_sys, // CPU clock
  input wire logic reset_in_oe, // Device pull on reset pin
  input wire logic ext_low, // External reset switch closed
  input wire logic cap_low, // Sense capacitor discharged
  input wire logic [3:0] filt_dly, // Filter lag in cycles
  output logic reset_in_pin, // Wired reset level
  output logic filtered_reset_in, // Filter output
  output logic powerdown_sense_pin // Sense level
);
  logic [15:0] hist = 16'hffff;
  // Pull-up on the wire: released means high
  assign reset_in_pin = !(reset_in_oe || ext_low);
  assign powerdown_sense_pin = !cap_low;
  // Lag on both edges, so low outlasts the release
  always_ff @(posedge clk_sys) begin
    hist <= {hist[14:0], reset_in_pin};
  end
  assign filtered_reset_in = hist[filt_dly];
endmodule : wbr_ext_model
`default_nettype wire

// ===== bench/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
  typedef struct {
    string nm;
    logic [31:0] val;
    logic [31:0] msk;
    logic [1:0] resp;
  } wbr_exp_s;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic filtered_reset_in, reset_in_pin, powerdown_sense_pin;
  logic software_reset_instr = 1'b0;
  logic end_of_init_instr = 1'b0;
  logic ext_low = 1'b0;
  logic cap_low = 1'b0;
  logic [3:0] filt_dly = 4'h0;
  wbr_pkg::wbr_bus_s bus = '0;
  logic [15:0] pins = 16'h0000;
  logic bus_abort, reset_in_oe, reset_in_o, reset_out_pin, cpu_reset;
  logic sense_pulldown, sense_pullup;
  logic [15:0] config_port;
  logic [3:0] s_axi_awaddr = 4'h0;
  logic [3:0] s_axi_araddr = 4'h0;
  logic [31:0] s_axi_wdata = 32'h0;
  logic s_axi_awvalid = 1'b0;
  logic s_axi_wvalid = 1'b0;
  logic s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic [31:0] cfg_exp;
  wbr_exp_s expq[$];
  int fail_count = 0;
  int n_compared = 0;

  always #4 clk_sys = ~clk_sys;

  wbr_ext_model ext (.clk_sys(clk_sys), .reset_in_oe(reset_in_oe),
    .ext_low(ext_low), .cap_low(cap_low), .filt_dly(filt_dly),
    .reset_in_pin(reset_in_pin), .filtered_reset_in(filtered_reset_in),
    .powerdown_sense_pin(powerdown_sense_pin));

  wbr_seq dut (.clk_sys(clk_sys), .rst_n(rst_n),
    .filtered_reset_in(filtered_reset_in), .reset_in_pin(reset_in_pin),
    .powerdown_sense_pin(powerdown_sense_pin),
    .external_boot_select(1'b0),
    .software_reset_instr(software_reset_instr),
    .end_of_init_instr(end_of_init_instr), .wdt_service(1'b0),
    .bus(bus), .config_port_pins(pins), .bus_abort(bus_abort),
    .reset_in_oe(reset_in_oe), .reset_in_o(reset_in_o),
    .reset_out_pin(reset_out_pin), .cpu_reset(cpu_reset),
    .sense_pulldown(sense_pulldown), .sense_pullup(sense_pullup),
    .config_port(config_port), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'hf),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));

  task stop_test;
    $display("Compared %0d, mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : stop_test

  task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
      fail_count++;
    end
  endtask : chk

  task tmo(input string nm);
    $display("[ERR] %s expected done seen timeout", nm);
    fail_count++;
    stop_test();
  endtask : tmo

  task cyc(input int n);
    repeat (n) @(posedge clk_sys);
  endtask : cyc

  // Read answers are judged by the monitor, in issue order
  always @(posedge clk_sys) begin
    wbr_exp_s e;
    if (s_axi_rvalid && s_axi_rready) begin
      if (expq.size() == 0) begin
        tmo("unexpected read");
      end else begin
        e = expq.pop_front();
        n_compared++;
        if ((s_axi_rdata & e.msk) !== e.val || s_axi_rresp !== e.resp) begin
          $display("[ERR] %s expected %h/%b seen %h/%b", e.nm, e.val,
            e.resp, s_axi_rdata & e.msk, s_axi_rresp);
          fail_count++;
        end
      end
    end
  end

  task wr(input logic [3:0] a, input logic [31:0] d);
    int i;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (i = 0; i < 50; i++) begin
      @(posedge clk_sys);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) break;
    end
    s_axi_bready <= 1'b0;
    if (i == 50) tmo("write");
    @(posedge clk_sys);
  endtask : wr

  task rd(input logic [3:0] a, input string nm, input logic [31:0] v,
          input logic [31:0] m, input logic [1:0] r);
    int i;
    expq.push_back('{nm, v & m, m, r});
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (i = 0; i < 50; i++) begin
      @(posedge clk_sys);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) break;
    end
    s_axi_rready <= 1'b0;
    if (i == 50) tmo("read");
    @(posedge clk_sys);
  endtask : rd

  task wait_cpu(input logic lvl, input int lim, input string nm);
    int i;
    for (i = 0; i < lim; i++) begin
      @(posedge clk_sys);
      if (cpu_reset === lvl) break;
    end
    if (i == lim) tmo(nm);
  endtask : wait_cpu

  task pulse_init;
    end_of_init_instr <= 1'b1;
    cyc(1);
    end_of_init_instr <= 1'b0;
    cyc(1);
  endtask : pulse_init

  task pulse_sw;
    software_reset_instr <= 1'b1;
    cyc(1);
    software_reset_instr <= 1'b0;
    cyc(3);
  endtask : pulse_sw

  initial begin
    int i;
    int n;
    logic seen;
    void'($urandom(32'hb392a203));
    pins = 16'($urandom());
    cfg_exp = {19'h0, pins[12:8], 8'hfc};
    cyc(10);
    rst_n <= 1'b1;
    cyc(1);
    rd(wbr_pkg::ADDR_SYSCFG, "syscfg", 32'h4, 32'h7, 2'b00);
    rd(wbr_pkg::ADDR_SOURCE, "source", 32'h0, 32'h1f, 2'b00);
    rd(4'h2, "unaligned", 32'h0, 32'h0, 2'b10);
    chk("reset_out", 32'h0, reset_out_pin);
    $display("Test reset values done");
    wr(wbr_pkg::ADDR_SYSCFG, 32'h5);
    rd(wbr_pkg::ADDR_SYSCFG, "bidir", 32'h5, 32'h7, 2'b00);
    pulse_init();
    cyc(3);
    chk("reset_out", 32'h1, reset_out_pin);
    pulse_sw();
    chk("reset_out", 32'h0, reset_out_pin);
    chk("oe", 32'h1, reset_in_oe);
    chk("pulldown", 32'h1, sense_pulldown);
    n = 0;
    for (i = 0; i < 2000 && reset_in_oe; i++) begin
      cyc(1);
      n++;
    end
    chk("oe span", 32'h1, 32'(n >= 500 && n <= 514));
    wait_cpu(1'b0, 100, "sw exit");
    rd(wbr_pkg::ADDR_SOURCE, "sw src", 32'h4, 32'h1f, 2'b00);
    rd(wbr_pkg::ADDR_SYSCFG, "cleared", 32'h0, 32'h1, 2'b00);
    rd(wbr_pkg::ADDR_CFGPORT, "sw cfg", cfg_exp, 32'h1ffc, 2'b00);
    $display("Test software bidir reset done");
    wr(wbr_pkg::ADDR_SYSCFG, 32'h5);
    filt_dly <= 4'hc;
    pulse_sw();
    wait_cpu(1'b0, 2000, "sw exit 2");
    cyc(20);
    wait_cpu(1'b0, 1000, "hw exit");
    rd(wbr_pkg::ADDR_SOURCE, "hw src", 32'h2, 32'h1f, 2'b00);
    filt_dly <= 4'h0;
    $display("Test degenerate reset done");
    wr(wbr_pkg::ADDR_SYSCFG, 32'h5);
    cap_low <= 1'b1;
    bus <= 4'hf;
    pulse_init();
    seen = 1'b0;
    for (i = 0; i < 70000 && bus_abort !== 1'b1; i++) begin
      cyc(1);
      seen = seen | reset_in_oe;
    end
    if (i == 70000) tmo("watchdog");
    chk("oe sense low", 32'h0, seen);
    bus <= 4'h0;
    cyc(3);
    chk("wdt reset", 32'h1, cpu_reset);
    wait_cpu(1'b0, 1000, "wdt exit");
    rd(wbr_pkg::ADDR_SOURCE, "wdt src", 32'h8, 32'h1f, 2'b00);
    rd(wbr_pkg::ADDR_CFGPORT, "wdt cfg", cfg_exp, 32'h1ffc, 2'b00);
    $display("Test watchdog reset done");
    ext_low <= 1'b1;
    cyc(4);
    chk("pulldown", 32'h1, sense_pulldown);
    cyc(16);
    chk("async", 32'h1, cpu_reset);
    ext_low <= 1'b0;
    cap_low <= 1'b0;
    wait_cpu(1'b0, 1000, "async exit");
    rd(wbr_pkg::ADDR_SOURCE, "async src", 32'h10, 32'h1f, 2'b00);
    $display("Test async reset done");
    wr(wbr_pkg::ADDR_SYSCFG, 32'h5);
    filt_dly <= 4'hc;
    ext_low <= 1'b1;
    cyc(5);
    ext_low <= 1'b0;
    cyc(20);
    chk("hw oe", 32'h1, reset_in_oe);
    wait_cpu(1'b0, 2000, "long exit");
    rd(wbr_pkg::ADDR_SOURCE, "long src", 32'h1, 32'h1f, 2'b00);
    $display("Test long hardware reset done");
    stop_test();
  end
endmodule : tb
`default_nettype wire
